// file: verilog/esp_pkg.sv
// Constants and types shared by the escape sequence parser
package esp_pkg;
    localparam logic [6:0] ESP_CH_SO    = 7'h0e;
    localparam logic [6:0] ESP_CH_SI    = 7'h0f;
    localparam logic [6:0] ESP_CH_CAN   = 7'h18;
    localparam logic [6:0] ESP_CH_SUB   = 7'h1a;
    localparam logic [6:0] ESP_CH_ESC   = 7'h1b;
    localparam logic [6:0] ESP_CH_SP    = 7'h20;
    localparam logic [6:0] ESP_CH_DEL   = 7'h7f;
    localparam logic [6:0] ESP_CH_G0DES = 7'h28;
    localparam logic [6:0] ESP_CH_G1DES = 7'h29;
    localparam logic [6:0] ESP_CH_CSI   = 7'h5b;
    localparam logic [6:0] ESP_CH_COLON = 7'h3a;
    localparam logic [6:0] ESP_CH_SEMI  = 7'h3b;
    localparam logic [6:0] ESP_CH_QUES  = 7'h3f;
    localparam logic [6:0] ESP_CH_ZERO  = 7'h30;
    localparam logic [6:0] ESP_INT_LO   = 7'h20;
    localparam logic [6:0] ESP_INT_HI   = 7'h2f;
    localparam logic [6:0] ESP_PAR_HI   = 7'h3f;
    localparam logic [6:0] ESP_DIG_HI   = 7'h39;
    localparam logic [6:0] ESP_C1_LO    = 7'h40;
    localparam logic [6:0] ESP_C1_HI    = 7'h5f;
    localparam logic [7:0] ESP_C1_OFS   = 8'h40;
    // Reset designation of both graphic slots
    localparam logic [6:0] ESP_SET_RST  = 7'h42;

    typedef enum logic [5:0] {
        ESP_GROUND  = 6'h01,
        ESP_ESC     = 6'h02,
        ESP_ESC_INT = 6'h04,
        ESP_CSI_PAR = 6'h08,
        ESP_CSI_INT = 6'h10,
        ESP_CSI_IGN = 6'h20
    } esp_state_t;
endpackage

// file: verilog/esp_parser.sv
// Escape and control sequence interpreter for a 7-bit character stream
`timescale 1ns/1ns
module esp_parser
    import esp_pkg::*;
#(
    parameter int NPARAM = 16,
    parameter int PW     = 16
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_b,
    input  wire logic                   i_char_valid,
    input  wire logic [6:0]             i_char,
    output logic                        o_ctrl_valid,
    output logic [6:0]                  o_ctrl_code,
    output logic                        o_graph_valid,
    output logic [6:0]                  o_graph_char,
    output logic [6:0]                  o_graph_set,
    output logic                        o_shift_g1,
    output logic [6:0]                  o_g0_set,
    output logic [6:0]                  o_g1_set,
    output logic                        o_esc_valid,
    output logic [6:0]                  o_esc_final,
    output logic [6:0]                  o_esc_inter,
    output logic [1:0]                  o_esc_ninter,
    output logic                        o_c1_valid,
    output logic [7:0]                  o_c1_code,
    output logic                        o_csi_valid,
    output logic [6:0]                  o_csi_final,
    output logic [6:0]                  o_csi_inter,
    output logic [1:0]                  o_csi_ninter,
    output logic                        o_csi_private,
    output logic [$clog2(NPARAM+1)-1:0] o_csi_count,
    output logic [NPARAM*PW-1:0]        o_csi_params
);
    localparam int IW = $clog2(NPARAM+1);
    localparam logic [IW-1:0] IDX_FULL = IW'(NPARAM);
    localparam logic [PW+3:0] VAL_MAX  = {4'h0, {PW{1'b1}}};

    typedef struct packed {
        esp_state_t                  st;
        logic [NPARAM-1:0][PW-1:0]   prm;
        logic [IW-1:0]               idx;
        logic                        priv;
        logic [6:0]                  inter;
        logic [1:0]                  ninter;
        logic [6:0]                  g0;
        logic [6:0]                  g1;
        logic                        shift;
        logic [6:0]                  gset;
        logic                        ctrl_v;
        logic [6:0]                  ctrl_c;
        logic                        graph_v;
        logic [6:0]                  graph_c;
        logic                        esc_v;
        logic [6:0]                  fin;
        logic                        c1_v;
        logic [7:0]                  c1_c;
        logic                        csi_v;
        logic [IW-1:0]               cnt;
    } esp_reg_t;

    esp_reg_t cur;
    esp_reg_t next_cur;

    function automatic logic in_rng(input logic [6:0] c,
                                    input logic [6:0] lo,
                                    input logic [6:0] hi);
        in_rng = (c >= lo) && (c <= hi);
    endfunction

    // Decimal accumulate with saturation at the field maximum
    function automatic logic [PW-1:0] acc_digit(input logic [PW-1:0] v,
                                                input logic [6:0]    c);
        logic [PW+3:0] s;
        s = ({4'h0, v} << 3) + ({4'h0, v} << 1)
            + {{PW{1'b0}}, c[3:0]};
        acc_digit = (s > VAL_MAX) ? {PW{1'b1}} : s[PW-1:0];
    endfunction

    logic is_c0;
    logic is_abort;
    logic is_int;

    always_comb begin
        next_cur = cur;
        next_cur.ctrl_v  = 1'b0;
        next_cur.graph_v = 1'b0;
        next_cur.esc_v   = 1'b0;
        next_cur.c1_v    = 1'b0;
        next_cur.csi_v   = 1'b0;
        is_c0    = i_char < ESP_CH_SP;
        is_abort = (i_char == ESP_CH_CAN) || (i_char == ESP_CH_SUB);
        is_int   = in_rng(i_char, ESP_INT_LO, ESP_INT_HI);
        if (i_char_valid) begin
            if (is_c0 && i_char != ESP_CH_ESC) begin
                // Executes ahead of any pending sequence
                next_cur.ctrl_v = 1'b1;
                next_cur.ctrl_c = i_char;
                if (i_char == ESP_CH_SO) begin
                    next_cur.shift = 1'b1;
                end else if (i_char == ESP_CH_SI) begin
                    next_cur.shift = 1'b0;
                end
                if (is_abort) begin
                    next_cur.st = ESP_GROUND;
                end
            end else if (i_char == ESP_CH_ESC) begin
                // A new introducer restarts collection
                next_cur.st     = ESP_ESC;
                next_cur.ninter = 2'h0;
                next_cur.inter  = 7'h00;
            end else if (i_char == ESP_CH_DEL) begin
                // Delete is dropped inside sequences
                if (cur.st == ESP_GROUND) begin
                    next_cur.ctrl_v = 1'b1;
                    next_cur.ctrl_c = i_char;
                end
            end else begin
                case (cur.st)
                    ESP_GROUND: begin
                        if (i_char == ESP_CH_SP) begin
                            next_cur.ctrl_v = 1'b1;
                            next_cur.ctrl_c = i_char;
                        end else begin
                            next_cur.graph_v = 1'b1;
                            next_cur.graph_c = i_char;
                        end
                    end
                    ESP_ESC, ESP_ESC_INT: begin
                        if (is_int) begin
                            next_cur.st = ESP_ESC_INT;
                            if (cur.ninter == 2'h0) begin
                                next_cur.inter = i_char;
                            end
                            if (cur.ninter != 2'h3) begin
                                next_cur.ninter = cur.ninter + 2'h1;
                            end
                        end else if (cur.st == ESP_ESC &&
                                     i_char == ESP_CH_CSI) begin
                            next_cur.st   = ESP_CSI_PAR;
                            next_cur.prm  = '0;
                            next_cur.idx  = '0;
                            next_cur.priv = 1'b0;
                        end else begin
                            next_cur.st  = ESP_GROUND;
                            next_cur.fin = i_char;
                            if (cur.ninter == 2'h1 &&
                                cur.inter == ESP_CH_G0DES) begin
                                next_cur.g0 = i_char;
                            end else if (cur.ninter == 2'h1 &&
                                         cur.inter == ESP_CH_G1DES) begin
                                next_cur.g1 = i_char;
                            end else if (cur.ninter == 2'h0 &&
                                 in_rng(i_char, ESP_C1_LO, ESP_C1_HI)) begin
                                // One-shot C1, e.g. index for ESC D
                                next_cur.c1_v = 1'b1;
                                next_cur.c1_c = {1'b0, i_char} + ESP_C1_OFS;
                            end else begin
                                // Meaning left to the consumer
                                next_cur.esc_v = 1'b1;
                            end
                        end
                    end
                    ESP_CSI_PAR, ESP_CSI_INT: begin
                        if (in_rng(i_char, ESP_CH_ZERO, ESP_PAR_HI)) begin
                            if (cur.st == ESP_CSI_INT) begin
                                // Parameter after intermediate
                                next_cur.st = ESP_CSI_IGN;
                            end else if (i_char <= ESP_DIG_HI) begin
                                if (cur.idx != IDX_FULL) begin
                                    next_cur.prm[cur.idx] =
                                        acc_digit(cur.prm[cur.idx],
                                                  i_char);
                                end
                            end else if (i_char == ESP_CH_SEMI) begin
                                if (cur.idx != IDX_FULL) begin
                                    next_cur.idx = cur.idx + 1'b1;
                                end
                            end else if (i_char == ESP_CH_QUES &&
                                         cur.idx == '0 &&
                                         cur.prm[0] == '0 &&
                                         !cur.priv) begin
                                next_cur.priv = 1'b1;
                            end else begin
                                // Colon, <, =, > or misplaced private marker
                                next_cur.st = ESP_CSI_IGN;
                            end
                        end else if (is_int) begin
                            next_cur.st = ESP_CSI_INT;
                            if (cur.ninter == 2'h0) begin
                                next_cur.inter = i_char;
                            end
                            if (cur.ninter != 2'h3) begin
                                next_cur.ninter = cur.ninter + 2'h1;
                            end
                        end else begin
                            // Each sequence stands alone: split equals joined
                            next_cur.st    = ESP_GROUND;
                            next_cur.fin   = i_char;
                            next_cur.csi_v = 1'b1;
                            next_cur.cnt   = (cur.idx == IDX_FULL) ?
                                             IDX_FULL : cur.idx + 1'b1;
                        end
                    end
                    ESP_CSI_IGN: begin
                        // Swallow up to the final, emit nothing
                        if (!in_rng(i_char, ESP_INT_LO, ESP_PAR_HI)) begin
                            next_cur.st = ESP_GROUND;
                        end
                    end
                    default: begin
                        next_cur.st = ESP_GROUND;
                    end
                endcase
            end
        end
        // Registered so the set output comes straight from a flip-flop
        next_cur.gset = next_cur.shift ? next_cur.g1 : next_cur.g0;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cur       <= '0;
            cur.st    <= ESP_GROUND;
            cur.g0    <= ESP_SET_RST;
            cur.g1    <= ESP_SET_RST;
            cur.gset  <= ESP_SET_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_ctrl_valid  = cur.ctrl_v;
    assign o_ctrl_code   = cur.ctrl_c;
    assign o_graph_valid = cur.graph_v;
    assign o_graph_char  = cur.graph_c;
    assign o_graph_set   = cur.gset;
    assign o_shift_g1    = cur.shift;
    assign o_g0_set      = cur.g0;
    assign o_g1_set      = cur.g1;
    assign o_esc_valid   = cur.esc_v;
    assign o_esc_final   = cur.fin;
    assign o_esc_inter   = cur.inter;
    assign o_esc_ninter  = cur.ninter;
    assign o_c1_valid    = cur.c1_v;
    assign o_c1_code     = cur.c1_c;
    assign o_csi_valid   = cur.csi_v;
    assign o_csi_final   = cur.fin;
    assign o_csi_inter   = cur.inter;
    assign o_csi_ninter  = cur.ninter;
    assign o_csi_private = cur.priv;
    assign o_csi_count   = cur.cnt;
    assign o_csi_params  = cur.prm;
endmodule

// file: test/esp_parser_props.sv
// Port checks for the escape sequence parser
`timescale 1ns/1ns
module esp_parser_props
    import esp_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst_b,
    input wire logic       i_char_valid,
    input wire logic [6:0] i_char,
    input wire logic       o_ctrl_valid,
    input wire logic [6:0] o_ctrl_code,
    input wire logic       o_graph_valid,
    input wire logic [6:0] o_graph_char,
    input wire logic [6:0] o_graph_set,
    input wire logic       o_shift_g1,
    input wire logic [6:0] o_g0_set,
    input wire logic [6:0] o_g1_set,
    input wire logic       o_c1_valid,
    input wire logic [7:0] o_c1_code,
    input wire logic       o_csi_valid
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    logic ctl;
    logic gfx;
    logic abt;
    // Shift codes left out: their pulse is not promised
    assign ctl = i_char_valid && i_char < ESP_CH_SP && i_char != ESP_CH_ESC
                 && i_char != ESP_CH_SO && i_char != ESP_CH_SI;
    assign gfx = i_char_valid && i_char > ESP_CH_SP && i_char < ESP_CH_DEL;
    assign abt = i_char_valid
                 && (i_char == ESP_CH_CAN || i_char == ESP_CH_SUB);
    property p_ctrl;
        ctl |=> o_ctrl_valid && o_ctrl_code == $past(i_char);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl pulse wrong");
    property p_so;
        i_char_valid && i_char == ESP_CH_SO |=> o_shift_g1;
    endproperty
    a_so: assert property (p_so) else $error("shift out lost");
    property p_si;
        i_char_valid && i_char == ESP_CH_SI |=> !o_shift_g1;
    endproperty
    a_si: assert property (p_si) else $error("shift in lost");
    property p_set;
        o_graph_set == (o_shift_g1 ? o_g1_set : o_g0_set);
    endproperty
    a_set: assert property (p_set) else $error("active set wrong");
    property p_graph;
        o_graph_valid |-> $past(i_char_valid) && o_graph_char == $past(i_char)
            && o_graph_char > ESP_CH_SP && o_graph_char < ESP_CH_DEL;
    endproperty
    a_graph: assert property (p_graph) else $error("graphic bad");
    property p_c1;
        o_c1_valid |-> o_c1_code == {1'b0, $past(i_char)} + ESP_C1_OFS;
    endproperty
    a_c1: assert property (p_c1) else $error("c1 code wrong");
    property p_csi;
        o_csi_valid |-> $past(i_char) >= ESP_C1_LO
            && $past(i_char) < ESP_CH_DEL;
    endproperty
    a_csi: assert property (p_csi) else $error("csi final wrong");
    property p_abort;
        abt ##1 gfx |=> o_graph_valid && !o_csi_valid;
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed");
    property p_g0;
        i_char_valid && i_char == ESP_CH_ESC ##1
        i_char_valid && i_char == ESP_CH_G0DES ##1
        i_char_valid && i_char >= ESP_CH_ZERO && i_char < ESP_CH_DEL
        |=> o_g0_set == $past(i_char);
    endproperty
    a_g0: assert property (p_g0) else $error("g0 designation lost");
endmodule
bind esp_parser esp_parser_props i_esp_parser_props (.i_sys_clk, .i_rst_b,
    .i_char_valid, .i_char, .o_ctrl_valid, .o_ctrl_code, .o_graph_valid,
    .o_graph_char, .o_graph_set, .o_shift_g1, .o_g0_set, .o_g1_set,
    .o_c1_valid, .o_c1_code, .o_csi_valid);

// file: test/esp_host_model.sv
// Host side character source for the parser
`timescale 1ns/1ns
module esp_host_model (
    input  wire logic       i_sys_clk,
    output logic            o_char_valid,
    output logic [6:0]      o_char
);
    initial begin
        o_char_valid = 1'b0;
        o_char = 7'h55;
    end
    // Seven bit codes only, held for one cycle each
    task automatic send(input logic [6:0] c);
        @(negedge i_sys_clk);
        o_char_valid = 1'b1;
        o_char = c;
    endtask
    // Idle bus toggles so a stale code is never mistaken
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge i_sys_clk);
            o_char_valid = 1'b0;
            o_char = ~o_char;
        end
    endtask
endmodule

// file: test/esp_parser_test.sv
// Self-checking bench for the escape sequence parser
`timescale 1ns/1ns
module esp_parser_test;
    import esp_pkg::*;
    localparam int NP = 16;
    localparam int PW = 16;
    logic                    i_sys_clk = 1'b0;
    logic                    i_rst_b   = 1'b0;
    logic                    cv, gv, gs, cs, c1v, ev, pv, prv;
    logic [6:0]              ch, cc, gc, gst, g0, g1, ef, ei, sf, si;
    logic [7:0]              c1c;
    logic [1:0]              en, sn;
    logic [$clog2(NP+1)-1:0] cnt;
    logic [NP*PW-1:0]        prms;
    logic [31:0]             r;
    int                      error_cnt, checks;
    int                      n_gr, n_ctl, n_csi, n_c1, n_esc;
    logic [6:0]              gr_last, ctl_last;
    string                   s;
    always #5 i_sys_clk = ~i_sys_clk;
    esp_host_model i_esp_host_model (.i_sys_clk(i_sys_clk),
        .o_char_valid(cv), .o_char(ch));
    esp_parser #(.NPARAM(NP), .PW(PW)) i_esp_parser (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_char_valid(cv), .i_char(ch), .o_ctrl_valid(gv),
        .o_ctrl_code(cc), .o_graph_valid(gs), .o_graph_char(gc),
        .o_graph_set(gst), .o_shift_g1(pv), .o_g0_set(g0), .o_g1_set(g1),
        .o_esc_valid(ev), .o_esc_final(ef), .o_esc_inter(ei),
        .o_esc_ninter(en), .o_c1_valid(c1v), .o_c1_code(c1c),
        .o_csi_valid(cs), .o_csi_final(sf), .o_csi_inter(si),
        .o_csi_ninter(sn), .o_csi_private(prv), .o_csi_count(cnt),
        .o_csi_params(prms));
    always @(negedge i_sys_clk) begin
        if (gs === 1'b1) begin n_gr++; gr_last = gc; end
        if (gv === 1'b1) begin n_ctl++; ctl_last = cc; end
        if (cs === 1'b1) n_csi++;
        if (c1v === 1'b1) n_c1++;
        if (ev === 1'b1) n_esc++;
    end
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic run(input string t);
        byte b;
        {n_gr, n_ctl, n_csi, n_c1, n_esc} = '0;
        foreach (t[i]) begin b = t[i]; i_esp_host_model.send(b[6:0]); end
        i_esp_host_model.idle(2);
    endtask
    // Decimal value of a digit string, saturating at the field width
    function automatic logic [15:0] dec(input string t);
        int v = 0;
        foreach (t[i]) begin
            v = v * 10 + (t[i] - 8'h30);
            if (v > 65535) v = 65535;
        end
        return v[15:0];
    endfunction
    function automatic logic [15:0] prm(input int k);
        return prms[k*PW +: PW];
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic conclude;
        $display("error_cnt %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        error_cnt++;
        conclude;
    end
    initial begin
        r = 32'h0000_71ef;
        repeat (6) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        chk("g0", ESP_SET_RST, g0);
        chk("g1", ESP_SET_RST, g1);
        chk("shift", 0, pv);
        run("\033[?3h");
        chk("csi", 1, n_csi);
        chk("priv", 1, prv);
        chk("final", 8'h68, sf);
        chk("p0", dec("3"), prm(0));
        run("\033[?03;004;5h");
        chk("cnt", 3, cnt);
        chk("p0", dec("03"), prm(0));
        chk("p1", dec("004"), prm(1));
        chk("p2", dec("5"), prm(2));
        run("\033[?5h");
        chk("split", dec("5"), prm(0));
        run("\033[;7H");
        chk("p0", 0, prm(0));
        chk("p1", 7, prm(1));
        chk("priv", 0, prv);
        run("\033[99999C");
        chk("sat", dec("99999"), prm(0));
        run("\033[1\0152A");
        chk("ctl", 8'h0d, ctl_last);
        chk("p0", dec("12"), prm(0));
        run("\033[3\0304h");
        chk("csi", 0, n_csi);
        chk("gr", 2, n_gr);
        run("\033(\032Q");
        chk("gr", 8'h51, gr_last);
        chk("g0", ESP_SET_RST, g0);
        run("\033[1?hA");
        chk("gr", 1, n_gr + n_csi);
        run("\033#6");
        chk("esc", 1, n_esc + n_gr);
        chk("inter", 8'h23, ei);
        chk("final", 8'h36, ef);
        chk("ninter", 1, en);
        run("\033[2 q");
        chk("final", 8'h71, sf);
        chk("inter", 8'h20, si);
        chk("ninter", 1, sn);
        chk("cnt", 1, cnt);
        chk("p0", 2, prm(0));
        for (int f = 64; f < 96; f++) begin
            if (f == 91) continue;
            s = "\033 ";
            s[1] = f[7:0];
            run(s);
            chk("c1", f + 8'h40, c1c);
        end
        run("\033(0\033)A\016");
        chk("set", 8'h41, gst);
        run(" \177");
        chk("ctl", 2, n_ctl + n_gr);
        run("\017");
        chk("set", 8'h30, gst);
        repeat (60) begin
            r = lfsr(r);
            s = " ";
            s[0] = 8'h21 + r % 94;
            run(s);
            chk("rnd", s[0], gr_last);
        end
        // Reset in mid-sequence with a shifted, redesignated state
        run("\033(0\016\033[5;6");
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        chk("g0", ESP_SET_RST, g0);
        chk("shift", 0, pv);
        chk("p1", 0, prm(1));
        run("h");
        chk("gr", 1, n_gr + n_csi);
        conclude;
    end
endmodule
